// ==== hw/ilx_ctrl.v ====
// Overview of operation
// - Each write with any byte strobe set to the current level register clears only its highest set bit.
// - A pending enabled flag whose level is above the current level raises a request.
// - Among several such flags only the highest level, lowest index one is presented.
// - The non-maskable request is presented regardless of the processor enable state.
// - Requests are held off from acceptance until the first handler instruction is done.
// - Requests are held off after a segment prefix until the next instruction is done.
// - Each of eight pins raises its own pending flag on its selected edge.
// - Each pin detects rising, falling or both edges, with or without sampling.
// - Each pin may be noise filtered and/or sampled on a tick of half the slow clock.
// - The timer trigger copy of each pin is always filtered and never sampled.
//
// Added by the designer: the address map and the AXI4-Lite register port.
`include "ilx_consts.vh"

module ilx_ctrl #(
  parameter NPIN = 8,
  parameter NLVL = 3
) (
  clk,
  rst_n,
  s_axi_awaddr,
  s_axi_awvalid,
  s_axi_awready,
  s_axi_wdata,
  s_axi_wstrb,
  s_axi_wvalid,
  s_axi_wready,
  s_axi_bresp,
  s_axi_bvalid,
  s_axi_bready,
  s_axi_araddr,
  s_axi_arvalid,
  s_axi_arready,
  s_axi_rdata,
  s_axi_rresp,
  s_axi_rvalid,
  s_axi_rready,
  ext_irq_pin,
  slow_clock,
  nmi_in,
  irq_ack,
  handler_first_done,
  dsr_prefix,
  dsr_next_done,
  nmi_ack,
  irq_req,
  irq_vec,
  irq_lvl,
  nmi_req,
  irq_o,
  ftm_trig
);
  input wire clk;
  input wire rst_n;
  input wire [31:0] s_axi_awaddr;
  input wire s_axi_awvalid;
  output wire s_axi_awready;
  input wire [31:0] s_axi_wdata;
  input wire [3:0] s_axi_wstrb;
  input wire s_axi_wvalid;
  output wire s_axi_wready;
  output reg [1:0] s_axi_bresp;
  output reg s_axi_bvalid;
  input wire s_axi_bready;
  input wire [31:0] s_axi_araddr;
  input wire s_axi_arvalid;
  output wire s_axi_arready;
  output reg [31:0] s_axi_rdata;
  output reg [1:0] s_axi_rresp;
  output reg s_axi_rvalid;
  input wire s_axi_rready;
  input wire [NPIN-1:0] ext_irq_pin;
  input wire slow_clock;
  input wire nmi_in;
  input wire irq_ack;
  input wire handler_first_done;
  input wire dsr_prefix;
  input wire dsr_next_done;
  input wire nmi_ack;
  output reg irq_req;
  output reg [2:0] irq_vec;
  output reg [1:0] irq_lvl;
  output reg nmi_req;
  output wire irq_o;
  output wire [NPIN-1:0] ftm_trig;

  // -------------------------------------------------------------------
  // Reset release
  // -------------------------------------------------------------------
  reg rst_s1_q;
  reg rst_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_q <= rst_s1_q;
    end
  end

  // -------------------------------------------------------------------
  // Functions
  // -------------------------------------------------------------------
  function [1:0] top_level;
    input [NLVL-1:0] current_level_reg;
    integer i;
    begin
      top_level = 2'h0;
      for (i = 0; i < NLVL; i = i + 1) begin
        if (current_level_reg[i]) begin
          top_level = i[1:0] + 2'h1;
        end
      end
    end
  endfunction

  function [15:0] merge16;
    input [15:0] old;
    input [15:0] wd;
    input [1:0] strb;
    begin
      merge16 = {strb[1] ? wd[15:8] : old[15:8], strb[0] ? wd[7:0] : old[7:0]};
    end
  endfunction

  // -------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------
  reg [NLVL-1:0] level_q;
  reg [NPIN-1:0] pend_q;
  reg [NPIN-1:0] enable_q;
  reg [15:0] src_lvl_q;
  reg [15:0] edge_sel_q;
  reg [15:0] filter_q;
  reg aw_have_q;
  reg w_have_q;
  reg [`ILX_ADDR_MSB:0] aw_addr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg hold_entry_q;
  reg hold_dsr_q;
  reg nmi_prev_q;
  reg sc_s1_q;
  reg sc_s2_q;
  reg sc_prev_q;
  reg div_q;
  reg tick_q;
  wire [NPIN-1:0] edge_p;
  wire do_wr;
  wire [NPIN-1:0] clr_mask;
  wire [NPIN-1:0] ack_mask;
  wire cil_wr;
  reg [1:0] cur_lvl;
  reg [1:0] best_lvl;
  reg [2:0] best_idx;
  reg any_hit;
  integer k;

  // -------------------------------------------------------------------
  // Sample tick at half the slow clock
  // -------------------------------------------------------------------
  always @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      sc_s1_q <= 1'b0;
      sc_s2_q <= 1'b0;
      sc_prev_q <= 1'b0;
      div_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      sc_s1_q <= slow_clock;
      sc_s2_q <= sc_s1_q;
      sc_prev_q <= sc_s2_q;
      tick_q <= 1'b0;
      if (sc_s2_q & ~sc_prev_q) begin
        div_q <= ~div_q;
        tick_q <= div_q;
      end
    end
  end

  // -------------------------------------------------------------------
  // External pins
  // -------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NPIN; g = g + 1) begin : g_pin
      ilx_pin u_pin (
        .clk(clk),
        .rst_n(rst_q),
        .pin(ext_irq_pin[g]),
        .tick(tick_q),
        .edge_sel(edge_sel_q[2*g+1:2*g]),
        .filt_en(filter_q[`ILX_FILT_EN_LSB+g]),
        .samp_en(filter_q[`ILX_SAMP_EN_LSB+g]),
        .edge_p(edge_p[g]),
        .ftm_trig(ftm_trig[g])
      );
    end
  endgenerate

  // -------------------------------------------------------------------
  // Register bus
  // -------------------------------------------------------------------
  assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_have_q & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign do_wr = aw_have_q & w_have_q & ~s_axi_bvalid;
  assign cil_wr = do_wr & (aw_addr_q == `ILX_OFS_LEVEL) & (|wstrb_q);
  assign clr_mask = (do_wr & (aw_addr_q == `ILX_OFS_CLEAR) & wstrb_q[0]) ?
                    wdata_q[NPIN-1:0] : {NPIN{1'b0}};
  assign ack_mask = irq_ack ? ({{(NPIN-1){1'b0}}, 1'b1} << irq_vec) : {NPIN{1'b0}};
  assign irq_o = |(pend_q & enable_q);

  always @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= {(`ILX_ADDR_MSB+1){1'b0}};
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ILX_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `ILX_RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      enable_q <= `ILX_RST_ENABLE;
      src_lvl_q <= `ILX_RST_SRC_LVL;
      edge_sel_q <= `ILX_RST_EDGE_SEL;
      filter_q <= `ILX_RST_FILTER;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= {s_axi_awaddr[`ILX_ADDR_MSB:2], 2'b00};
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `ILX_RESP_OKAY;
        case (aw_addr_q)
          `ILX_OFS_LEVEL: ;
          `ILX_OFS_CLEAR: ;
          `ILX_OFS_STATUS: ;
          `ILX_OFS_ENABLE: begin
            if (wstrb_q[0]) begin
              enable_q <= wdata_q[NPIN-1:0];
            end
          end
          `ILX_OFS_SRC_LVL: src_lvl_q <= merge16(src_lvl_q, wdata_q[15:0], wstrb_q[1:0]);
          `ILX_OFS_EDGE_SEL: edge_sel_q <= merge16(edge_sel_q, wdata_q[15:0], wstrb_q[1:0]);
          `ILX_OFS_FILTER: filter_q <= merge16(filter_q, wdata_q[15:0], wstrb_q[1:0]);
          default: s_axi_bresp <= `ILX_RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `ILX_RESP_OKAY;
        s_axi_rdata <= 32'h0000_0000;
        case ({s_axi_araddr[`ILX_ADDR_MSB:2], 2'b00})
          `ILX_OFS_LEVEL: s_axi_rdata[NLVL-1:0] <= level_q;
          `ILX_OFS_STATUS: s_axi_rdata[NPIN-1:0] <= pend_q;
          `ILX_OFS_CLEAR: ;
          `ILX_OFS_ENABLE: s_axi_rdata[NPIN-1:0] <= enable_q;
          `ILX_OFS_SRC_LVL: s_axi_rdata[15:0] <= src_lvl_q;
          `ILX_OFS_EDGE_SEL: s_axi_rdata[15:0] <= edge_sel_q;
          `ILX_OFS_FILTER: s_axi_rdata[15:0] <= filter_q;
          default: s_axi_rresp <= `ILX_RESP_SLVERR;
        endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------------
  // Arbitration
  // -------------------------------------------------------------------
  always @* begin
    cur_lvl = top_level(level_q);
    best_lvl = 2'h0;
    best_idx = 3'h0;
    any_hit = 1'b0;
    for (k = 0; k < NPIN; k = k + 1) begin
      // Strictly greater keeps the lowest index on a tie.
      if (pend_q[k] & enable_q[k] & (src_lvl_q[2*k+:2] > cur_lvl) &
          (src_lvl_q[2*k+:2] > best_lvl)) begin
        best_lvl = src_lvl_q[2*k+:2];
        best_idx = k[2:0];
        any_hit = 1'b1;
      end
    end
  end

  // -------------------------------------------------------------------
  // Level, pending flags and processor request
  // -------------------------------------------------------------------
  always @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      level_q <= `ILX_RST_LEVEL;
      pend_q <= {NPIN{1'b0}};
      hold_entry_q <= 1'b0;
      hold_dsr_q <= 1'b0;
      nmi_prev_q <= 1'b0;
      nmi_req <= 1'b0;
      irq_req <= 1'b0;
      irq_vec <= 3'h0;
      irq_lvl <= 2'h0;
    end else begin
      // A clear write removes the top bit; an accept in the same cycle still lands.
      if (cil_wr & (cur_lvl != 2'h0)) begin
        if (irq_ack & (irq_lvl != 2'h0)) begin
          level_q <= (level_q & ~({{(NLVL-1){1'b0}}, 1'b1} << (cur_lvl - 2'h1))) |
                     ({{(NLVL-1){1'b0}}, 1'b1} << (irq_lvl - 2'h1));
        end else begin
          level_q <= level_q & ~({{(NLVL-1){1'b0}}, 1'b1} << (cur_lvl - 2'h1));
        end
      end else if (irq_ack & (irq_lvl != 2'h0)) begin
        level_q <= level_q | ({{(NLVL-1){1'b0}}, 1'b1} << (irq_lvl - 2'h1));
      end
      pend_q <= (pend_q & ~(clr_mask | ack_mask)) | edge_p;
      if (irq_ack) begin
        hold_entry_q <= 1'b1;
      end else if (handler_first_done) begin
        hold_entry_q <= 1'b0;
      end
      if (dsr_prefix) begin
        hold_dsr_q <= 1'b1;
      end else if (dsr_next_done) begin
        hold_dsr_q <= 1'b0;
      end
      nmi_prev_q <= nmi_in;
      if (nmi_in & ~nmi_prev_q) begin
        nmi_req <= 1'b1;
      end else if (nmi_ack) begin
        nmi_req <= 1'b0;
      end
      irq_req <= any_hit & ~hold_entry_q & ~hold_dsr_q & ~irq_ack & ~dsr_prefix;
      irq_vec <= best_idx;
      irq_lvl <= best_lvl;
    end
  end
endmodule // ilx_ctrl

// ==== hw/ilx_consts.vh ====
`ifndef ILX_CONSTS_VH
`define ILX_CONSTS_VH

// ---------------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------------
`define ILX_OFS_LEVEL 6'h00
`define ILX_OFS_STATUS 6'h04
`define ILX_OFS_CLEAR 6'h08
`define ILX_OFS_ENABLE 6'h0c
`define ILX_OFS_SRC_LVL 6'h10
`define ILX_OFS_EDGE_SEL 6'h14
`define ILX_OFS_FILTER 6'h18

// ---------------------------------------------------------------------
// Field layouts and reset values
// ---------------------------------------------------------------------
`define ILX_ADDR_MSB 5
`define ILX_FILT_EN_LSB 0
`define ILX_SAMP_EN_LSB 8
`define ILX_RST_LEVEL 3'h0
`define ILX_RST_SRC_LVL 16'h0000
`define ILX_RST_EDGE_SEL 16'h0000
`define ILX_RST_FILTER 16'h0000
`define ILX_RST_ENABLE 8'h00

// ---------------------------------------------------------------------
// Edge select codes
// ---------------------------------------------------------------------
`define ILX_EDGE_OFF 2'h0
`define ILX_EDGE_RISE 2'h1
`define ILX_EDGE_FALL 2'h2
`define ILX_EDGE_BOTH 2'h3

// ---------------------------------------------------------------------
// AXI responses and timing
// ---------------------------------------------------------------------
`define ILX_RESP_OKAY 2'h0
`define ILX_RESP_SLVERR 2'h2
`define ILX_NF_TAPS 3

`endif

// ==== hw/ilx_pin.v ====
`include "ilx_consts.vh"

module ilx_pin (
  clk,
  rst_n,
  pin,
  tick,
  edge_sel,
  filt_en,
  samp_en,
  edge_p,
  ftm_trig
);
  input wire clk;
  input wire rst_n;
  input wire pin;
  input wire tick;
  input wire [1:0] edge_sel;
  input wire filt_en;
  input wire samp_en;
  output reg edge_p;
  output reg ftm_trig;

  reg s1_q;
  reg s2_q;
  reg [`ILX_NF_TAPS-1:0] hist_q;
  reg filt_q;
  reg ph_q;
  reg samp_q;
  reg prev_q;
  wire pre;
  wire lvl;
  wire rise;
  wire fall;
  reg hit;

  assign pre = filt_en ? filt_q : s2_q;
  assign lvl = samp_en ? samp_q : pre;
  assign rise = lvl & ~prev_q;
  assign fall = ~lvl & prev_q;

  always @* begin
    case (edge_sel)
      `ILX_EDGE_RISE: hit = rise;
      `ILX_EDGE_FALL: hit = fall;
      `ILX_EDGE_BOTH: hit = rise | fall;
      default: hit = 1'b0;
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      hist_q <= {`ILX_NF_TAPS{1'b0}};
      filt_q <= 1'b0;
      ph_q <= 1'b0;
      samp_q <= 1'b0;
      prev_q <= 1'b0;
      edge_p <= 1'b0;
      ftm_trig <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      hist_q <= {hist_q[`ILX_NF_TAPS-2:0], s2_q};
      // The filter only moves once every tap agrees.
      if (&hist_q) begin
        filt_q <= 1'b1;
      end else if (~|hist_q) begin
        filt_q <= 1'b0;
      end
      // Two-phase sampling: two successive ticks must agree.
      if (tick) begin
        ph_q <= pre;
        if (ph_q == pre) begin
          samp_q <= pre;
        end
      end
      prev_q <= lvl;
      edge_p <= hit;
      ftm_trig <= filt_q;
    end
  end
endmodule // ilx_pin

// ==== bench/ilx_ctrl_chk.sv ====
module ilx_ctrl_chk #(
  parameter NPIN = 8
) (
  input wire clk,
  input wire rst_n,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [NPIN-1:0] ext_irq_pin,
  input wire [NPIN-1:0] ftm_trig,
  input wire nmi_in,
  input wire nmi_req,
  input wire nmi_ack,
  input wire irq_ack,
  input wire irq_req,
  input wire [1:0] irq_lvl,
  input wire handler_first_done,
  input wire dsr_prefix,
  input wire dsr_next_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic entry_q;
  logic dsr_q;
  // Mirrors of the two acceptance holds, opened and closed by the core strobes.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      entry_q <= 1'b0;
      dsr_q <= 1'b0;
    end else begin
      entry_q <= irq_ack | (entry_q & ~handler_first_done);
      dsr_q <= dsr_prefix | (dsr_q & ~dsr_next_done);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_ack_drop; irq_ack |=> !irq_req; endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("request kept after accept");
  property p_entry_hold; entry_q |=> !irq_req; endproperty
  a_entry_hold: assert property (p_entry_hold) else $error("request in entry hold");
  property p_dsr_hold; (dsr_q || dsr_prefix) |=> !irq_req; endproperty
  a_dsr_hold: assert property (p_dsr_hold) else $error("request after prefix");
  property p_nmi_rise; $rose(nmi_in) |-> ##[1:2] nmi_req; endproperty
  a_nmi_rise: assert property (p_nmi_rise) else $error("nmi not raised");
  property p_nmi_keep; nmi_req && !nmi_ack |=> nmi_req; endproperty
  a_nmi_keep: assert property (p_nmi_keep) else $error("nmi dropped unaccepted");
  property p_lvl_set; irq_req |-> irq_lvl != 2'h0; endproperty
  a_lvl_set: assert property (p_lvl_set) else $error("request at level zero");
  property p_ftm; $stable(ext_irq_pin) [*8] |-> ftm_trig == ext_irq_pin; endproperty
  a_ftm: assert property (p_ftm) else $error("timer copy differs from pins");
  property p_b_keep; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_b_keep: assert property (p_b_keep) else $error("write response withdrawn");
  property p_r_keep; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
  a_r_keep: assert property (p_r_keep) else $error("read response withdrawn");
  c_ack: cover property (irq_ack);
  c_nmi: cover property (nmi_ack);
  c_dsr: cover property (dsr_q && dsr_next_done);
endmodule // ilx_ctrl_chk

bind ilx_ctrl ilx_ctrl_chk #(.NPIN(NPIN)) chk_u (
  .clk(clk), .rst_n(rst_n), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .ext_irq_pin(ext_irq_pin),
  .ftm_trig(ftm_trig), .nmi_in(nmi_in), .nmi_req(nmi_req), .nmi_ack(nmi_ack),
  .irq_ack(irq_ack), .irq_req(irq_req), .irq_lvl(irq_lvl),
  .handler_first_done(handler_first_done), .dsr_prefix(dsr_prefix),
  .dsr_next_done(dsr_next_done)
);

// ==== bench/ilx_core_model.sv ====
module ilx_core_model (
  input wire clk,
  input wire rst_n,
  input wire auto_ack,
  input wire [7:0] first_gap,
  input wire irq_req,
  input wire [2:0] irq_vec,
  input wire nmi_req,
  output logic irq_ack,
  output logic handler_first_done,
  output logic nmi_ack,
  output logic dsr_prefix,
  output logic dsr_next_done,
  output logic [7:0] ack_cnt,
  output logic [7:0] nmi_cnt,
  output logic [2:0] last_vec
);
  timeunit 1ns;
  timeprecision 1ps;
  logic req_q;
  logic [7:0] gap_q;
  initial begin
    dsr_prefix = 1'b0;
    dsr_next_done = 1'b0;
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_ack <= 1'b0;
      handler_first_done <= 1'b0;
      nmi_ack <= 1'b0;
      req_q <= 1'b0;
      gap_q <= 8'h00;
      ack_cnt <= 8'h00;
      nmi_cnt <= 8'h00;
      last_vec <= 3'h0;
    end else begin
      irq_ack <= 1'b0;
      handler_first_done <= 1'b0;
      nmi_ack <= 1'b0;
      req_q <= irq_req;
      if (gap_q != 8'h00) gap_q <= gap_q - 8'h01;
      // The handler saves its state, then its first instruction re-enables nesting.
      if (gap_q == 8'h01) handler_first_done <= 1'b1;
      // A request is taken once it has stood for two cycles, the slow answer.
      if (auto_ack && irq_req && req_q && !irq_ack) begin
        irq_ack <= 1'b1;
        ack_cnt <= ack_cnt + 8'h01;
        last_vec <= irq_vec;
        gap_q <= first_gap;
      end
      if (nmi_req && !nmi_ack) begin
        nmi_ack <= 1'b1;
        nmi_cnt <= nmi_cnt + 8'h01;
      end
    end
  end
  task pulse(input logic nxt);
    @(posedge clk);
    if (nxt) dsr_next_done <= 1'b1;
    else dsr_prefix <= 1'b1;
    @(posedge clk);
    dsr_prefix <= 1'b0;
    dsr_next_done <= 1'b0;
  endtask
endmodule // ilx_core_model

// ==== bench/interrupt_level_and_ext_irq_test.sv ====
`include "ilx_consts.vh"

module interrupt_level_and_ext_irq_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0] rsp_ok = `ILX_RESP_OKAY;
  logic clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, slow_clock;
  logic nmi_in, irq_ack, handler_first_done, dsr_prefix, dsr_next_done, nmi_ack, irq_req;
  logic irq_o, nmi_req, auto_ack;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, a, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, irq_lvl;
  logic [2:0] irq_vec, last_vec, slow_cnt;
  logic [7:0] ext_irq_pin, ftm_trig, ack_cnt, nmi_cnt, first_gap;
  logic [7:0] steps [3] = '{8'h01, 8'h09, 8'h0f};
  logic [7:0] lvls [3] = '{8'h01, 8'h03, 8'h07};
  logic [7:0] drops [3] = '{8'h03, 8'h01, 8'h00};
  logic [2:0] vecs [3] = '{3'h0, 3'h3, 3'h1};
  int mismatches, checks, i;

  ilx_ctrl #(.NPIN(8)) dut_u (.*);
  ilx_core_model core_u (.clk(clk), .rst_n(rst_n), .auto_ack(auto_ack), .first_gap(first_gap),
    .irq_req(irq_req), .irq_vec(irq_vec), .nmi_req(nmi_req), .irq_ack(irq_ack),
    .handler_first_done(handler_first_done), .nmi_ack(nmi_ack), .dsr_prefix(dsr_prefix),
    .dsr_next_done(dsr_next_done), .ack_cnt(ack_cnt), .nmi_cnt(nmi_cnt), .last_vec(last_vec));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Slow clock of eight system cycles, so the sampling tick comes every sixteen.
  always @(posedge clk) begin
    slow_cnt <= slow_cnt + 3'h1;
    slow_clock <= slow_cnt[2];
  end

  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task wrap_up;
    $display("checks %0d, mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task axi_wr(input logic [31:0] ad, input logic [31:0] dt, input logic [1:0] er);
    int n;
    @(posedge clk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= dt;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (n == 50) begin
      chk("write wait", 32'h0, 32'h1);
      wrap_up;
    end
    s_axi_bready <= 1'b0;
    chk("write response", 32'(s_axi_bresp), 32'(er));
  endtask
  task axi_rd(input logic [31:0] ad, output logic [31:0] dt, input logic [1:0] er);
    int n;
    @(posedge clk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (n == 50) begin
      chk("read wait", 32'h0, 32'h1);
      wrap_up;
    end
    s_axi_rready <= 1'b0;
    dt = s_axi_rdata;
    chk("read response", 32'(s_axi_rresp), 32'(er));
  endtask
  task rd_chk(input string what, input logic [31:0] ad, input logic [31:0] exp);
    logic [31:0] v;
    axi_rd(ad, v, rsp_ok);
    chk(what, v, exp);
  endtask
  task wait_for(input logic nmi, input logic [7:0] t);
    int n;
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      if ((nmi ? nmi_cnt : ack_cnt) == t) break;
    end
    if (n == 200) begin
      chk("accept wait", 32'h0, 32'h1);
      wrap_up;
    end
  endtask

  initial begin
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    {nmi_in, auto_ack, slow_clock, slow_cnt, ext_irq_pin} = 14'h0000;
    s_axi_wstrb = 4'hf;
    first_gap = 8'h1e;
    mismatches = 0;
    checks = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (a = 32'h0; a <= 32'h18; a += 32'h4) rd_chk("reset value", a, 32'h0);
    axi_rd(32'h1c, d, `ILX_RESP_SLVERR);
    axi_wr(32'h1c, 32'h0000_ffff, `ILX_RESP_SLVERR);
    $display("test registers done");
    axi_wr(`ILX_OFS_EDGE_SEL, 32'h0000_0539, rsp_ok);
    axi_wr(`ILX_OFS_FILTER, 32'h0000_1020, rsp_ok);
    ext_irq_pin <= 8'h3f;
    repeat (100) @(posedge clk);
    rd_chk("rising edges", `ILX_OFS_STATUS, 32'h0000_0035);
    chk("masked output", 32'(irq_o), 32'h0);
    axi_wr(`ILX_OFS_ENABLE, 32'h0000_00ff, rsp_ok);
    chk("enabled output", 32'(irq_o), 32'h1);
    axi_wr(`ILX_OFS_STATUS, 32'h0, rsp_ok);
    rd_chk("status kept", `ILX_OFS_STATUS, 32'h0000_0035);
    axi_wr(`ILX_OFS_CLEAR, 32'h0000_00ff, rsp_ok);
    rd_chk("cleared status", `ILX_OFS_STATUS, 32'h0);
    rd_chk("clear readback", `ILX_OFS_CLEAR, 32'h0);
    chk("cleared output", 32'(irq_o), 32'h0);
    ext_irq_pin <= 8'h00;
    repeat (100) @(posedge clk);
    rd_chk("falling edges", `ILX_OFS_STATUS, 32'h0000_0006);
    axi_wr(`ILX_OFS_CLEAR, 32'h0000_00ff, rsp_ok);
    $display("test pins done");
    axi_wr(`ILX_OFS_SRC_LVL, 32'h0000_00bd, rsp_ok);
    axi_wr(`ILX_OFS_EDGE_SEL, 32'h0000_0055, rsp_ok);
    axi_wr(`ILX_OFS_FILTER, 32'h0, rsp_ok);
    axi_wr(`ILX_OFS_ENABLE, 32'h0000_000f, rsp_ok);
    auto_ack <= 1'b1;
    for (i = 0; i < 3; i++) begin
      ext_irq_pin <= steps[i];
      if (i > 0) begin
        repeat (12) @(posedge clk);
        chk("held in entry", 32'(ack_cnt), 32'(i));
      end
      wait_for(1'b0, 8'(i + 1));
      chk("taken source", 32'(last_vec), 32'(vecs[i]));
      rd_chk("level", `ILX_OFS_LEVEL, 32'(lvls[i]));
    end
    repeat (40) @(posedge clk);
    chk("same level held", 32'(ack_cnt), 32'h3);
    rd_chk("waiting source", `ILX_OFS_STATUS, 32'h0000_0004);
    axi_wr(`ILX_OFS_LEVEL, 32'h0, rsp_ok);
    wait_for(1'b0, 8'h04);
    chk("taken source", 32'(last_vec), 32'h2);
    rd_chk("level", `ILX_OFS_LEVEL, 32'h7);
    for (i = 0; i < 3; i++) begin
      axi_wr(`ILX_OFS_LEVEL, 32'h0000_0007, rsp_ok);
      rd_chk("lowered level", `ILX_OFS_LEVEL, 32'(drops[i]));
    end
    $display("test priority done");
    ext_irq_pin <= 8'h00;
    repeat (10) @(posedge clk);
    core_u.pulse(1'b0);
    ext_irq_pin <= 8'h01;
    nmi_in <= 1'b1;
    repeat (12) @(posedge clk);
    chk("held after prefix", 32'(ack_cnt), 32'h4);
    chk("nmi taken", 32'(nmi_cnt), 32'h1);
    core_u.pulse(1'b1);
    wait_for(1'b0, 8'h05);
    chk("deferred source", 32'(last_vec), 32'h0);
    axi_wr(`ILX_OFS_LEVEL, 32'h0, rsp_ok);
    nmi_in <= 1'b0;
    $display("test holds done");
    wrap_up;
  end
endmodule // interrupt_level_and_ext_irq_test
